// ===== include/tpdo_pkg.sv
package tpdo_pkg;

  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;

  // Timebase
  localparam int CLK_PERIOD_NS   = 10;
  localparam int INH_UNIT_NS     = 100_000;
  localparam int EVT_UNIT_NS     = 1_000_000;
  localparam int TICK100_CYCLES  = INH_UNIT_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS    = EVT_UNIT_NS / INH_UNIT_NS;
  localparam int TICK_W          = 14;

  // Register byte offsets
  localparam addr_t OFS_CTRL     = 8'h00;
  localparam addr_t OFS_COBID    = 8'h04;
  localparam addr_t OFS_TTYPE    = 8'h08;
  localparam addr_t OFS_INHIBIT  = 8'h0C;
  localparam addr_t OFS_EVT      = 8'h10;
  localparam addr_t OFS_SYNCID   = 8'h14;
  localparam addr_t OFS_STATUS   = 8'h18;

  // Field positions
  localparam int CTRL_OPER_BIT   = 0;
  localparam int CTRL_NODE_LSB   = 8;
  localparam int COB_DIS_BIT     = 31;

  // Reset values
  localparam logic        OPER_RST    = 1'b0;
  localparam logic [6:0]  NODE_RST    = 7'h01;
  localparam logic        COB_DIS_RST = 1'b0;
  localparam logic [7:0]  TTYPE_RST   = 8'hFE;
  localparam logic [15:0] INHIBIT_RST = 16'h0000;
  localparam logic [15:0] EVT_RST     = 16'h0000;
  localparam logic [10:0] SYNCID_RST  = 11'h080;

  // Transmission types and identifiers
  localparam logic [7:0]  TTYPE_ACYC     = 8'h00;
  localparam logic [7:0]  TTYPE_SYNC_MAX = 8'hF0;
  localparam logic [7:0]  TTYPE_RTR      = 8'hFD;
  localparam logic [7:0]  TTYPE_ASYNC    = 8'hFE;
  localparam logic [10:0] TPDO_BASE_ID   = 11'h180;

  localparam int TX_W = 43;

  function automatic logic isCyclic(input logic [7:0] t);
    isCyclic = (t != TTYPE_ACYC) && (t <= TTYPE_SYNC_MAX);
  endfunction : isCyclic

  function automatic word_t beMerge(input word_t old, input word_t nw, input logic [3:0] be);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    beMerge = r;
  endfunction : beMerge

endpackage : tpdo_pkg

// ===== include/tx_stream_if.sv
`timescale 1ns/1ns
interface tx_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : tx_stream_if

// ===== verilog/tx_skid_buffer.sv
`timescale 1ns/1ns
module tx_skid_buffer #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,   // System clock
  input  wire logic         rst,       // Synchronous reset
  tx_stream_if.snk          inPort,    // Filling side
  output logic              outValid,  // Word on offer
  output logic [W-1:0]      outData,   // Offered word
  input  wire logic         outReady   // Receiver takes word
);
  logic         outValid_q, outValid_d;
  logic [W-1:0] outData_q, outData_d;
  logic         skidValid_q, skidValid_d;
  logic [W-1:0] skidData_q, skidData_d;
  logic         accept;

  // Ready comes from a flop so the source never sees a combinational loop
  assign inPort.ready = ~skidValid_q;
  assign accept       = inPort.valid & ~skidValid_q;

  always_comb begin
    outValid_d  = outValid_q;
    outData_d   = outData_q;
    skidValid_d = skidValid_q;
    skidData_d  = skidData_q;
    if (!outValid_q || outReady) begin
      if (skidValid_q) begin
        outValid_d  = 1'b1;
        outData_d   = skidData_q;
        skidValid_d = accept;
        skidData_d  = inPort.data;
      end else begin
        outValid_d = accept;
        outData_d  = inPort.data;
      end
    end else if (accept) begin
      skidValid_d = 1'b1;
      skidData_d  = inPort.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outValid_q  <= 1'b0;
      outData_q   <= '0;
      skidValid_q <= 1'b0;
      skidData_q  <= '0;
    end else begin
      outValid_q  <= outValid_d;
      outData_q   <= outData_d;
      skidValid_q <= skidValid_d;
      skidData_q  <= skidData_d;
    end
  end

  assign outValid = outValid_q;
  assign outData  = outData_q;

  property p_hold;
    @(posedge sys_clk) disable iff (rst) outValid_q && !outReady |=> outValid_q && $stable(outData_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Stalled word changed");

endmodule : tx_skid_buffer

// ===== verilog/tpdo_transmission_scheduler.sv
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module tpdo_transmission_scheduler #(
  parameter int TICK_CYCLES = tpdo_pkg::TICK100_CYCLES  // Cycles per 100 us tick
) (
  input  wire logic              sys_clk,          // 100 MHz clock
  input  wire logic              rst,              // Synchronous reset, high
  input  wire tpdo_pkg::addr_t   avs_address,      // Byte address
  input  wire logic              avs_read,         // Read request
  input  wire logic              avs_write,        // Write request
  input  wire tpdo_pkg::word_t   avs_writedata,    // Write data
  input  wire logic [3:0]        avs_byteenable,   // Byte lanes
  output tpdo_pkg::word_t        avs_readdata,     // Read data
  output logic                   avs_waitrequest,  // Stall request
  input  wire logic              rxValid,          // Received frame pulse
  input  wire logic [10:0]       rxId,             // Received identifier
  input  wire logic              rxRtr,            // Received frame is remote
  input  wire logic              incChange,        // Inclination changed pulse
  input  wire tpdo_pkg::word_t   measValue,        // Current measurement
  output logic                   txValid,          // Frame on offer
  output logic [10:0]            txId,             // Frame identifier
  output tpdo_pkg::word_t        txData,           // Frame payload
  input  wire logic              txReady           // Transmitter takes frame
);
  import tpdo_pkg::*;

  logic          ack_q, ack_d;
  logic          waitReq_q, waitReq_d;
  word_t         rdata_q, rdata_d;
  logic          oper_q, oper_d;
  logic [6:0]    nodeId_q, nodeId_d;
  logic          cobDis_q, cobDis_d;
  logic [7:0]    ttype_q, ttype_d;
  logic [15:0]   inhibit_q, inhibit_d;
  logic [15:0]   evtPeriod_q, evtPeriod_d;
  logic [10:0]   syncId_q, syncId_d;

  logic [TICK_W-1:0] tickCnt_q, tickCnt_d;
  logic [3:0]    msCnt_q, msCnt_d;
  logic [15:0]   evtCnt_q, evtCnt_d;
  logic [7:0]    syncCnt_q, syncCnt_d;
  logic          evtPend_q, evtPend_d;
  logic          pend_q, pend_d;
  logic [16:0]   inhCnt_q, inhCnt_d;
  logic [15:0]   txCount_q, txCount_d;

  word_t         curWord;
  word_t         merged;
  logic          wrHit;
  logic          wrTtype;
  logic          wrEvt;
  logic [10:0]   txBaseId;
  logic          tick;
  logic          msTick;
  logic          evtFire;
  logic          evtSrc;
  logic          canSend;
  logic          syncHit;
  logic          rtrHit;
  logic          isCyc;
  logic          syncDone;
  logic          trig;
  logic          intValid;
  logic          emit;

  tx_stream_if #(.W(TX_W)) txStream ();
  assign txBaseId = TPDO_BASE_ID + {4'h0, nodeId_q};
  assign wrHit    = avs_write & ack_q;
  assign wrTtype  = wrHit & (avs_address == OFS_TTYPE);
  assign wrEvt    = wrHit & (avs_address == OFS_EVT);

  always_comb begin
    case (avs_address)
      OFS_CTRL:    curWord = {17'h0_0000, nodeId_q, 7'h00, oper_q};
      OFS_COBID:   curWord = {cobDis_q, 20'h0_0000, txBaseId};
      OFS_TTYPE:   curWord = {24'h00_0000, ttype_q};
      OFS_INHIBIT: curWord = {16'h0000, inhibit_q};
      OFS_EVT:     curWord = {16'h0000, evtPeriod_q};
      OFS_SYNCID:  curWord = {21'h00_0000, syncId_q};
      OFS_STATUS:  curWord = {txCount_q, 5'h00, (inhCnt_q != 17'h0_0000), evtPend_q, pend_q, syncCnt_q};
      default:     curWord = 32'h0000_0000;
    endcase
  end

  assign merged = beMerge(curWord, avs_writedata, avs_byteenable);

  // One wait cycle per access; the answer is ready in the second cycle
  always_comb begin
    ack_d       = (avs_read | avs_write) & ~ack_q;
    waitReq_d   = ~ack_d;
    rdata_d     = (ack_d && avs_read) ? curWord : rdata_q;
    oper_d      = oper_q;
    nodeId_d    = nodeId_q;
    cobDis_d    = cobDis_q;
    ttype_d     = ttype_q;
    inhibit_d   = inhibit_q;
    evtPeriod_d = evtPeriod_q;
    syncId_d    = syncId_q;
    if (wrHit) begin
      case (avs_address)
        OFS_CTRL: begin
          oper_d   = merged[CTRL_OPER_BIT];
          nodeId_d = merged[CTRL_NODE_LSB +: 7];
        end
        OFS_COBID:   cobDis_d    = merged[COB_DIS_BIT];
        OFS_TTYPE:   ttype_d     = merged[7:0];
        OFS_INHIBIT: inhibit_d   = cobDis_q ? merged[15:0] : inhibit_q;
        OFS_EVT:     evtPeriod_d = merged[15:0];
        OFS_SYNCID:  syncId_d    = (merged[10:0] != 11'h000) ? merged[10:0] : syncId_q;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q       <= 1'b0;
      waitReq_q   <= 1'b1;
      rdata_q     <= 32'h0000_0000;
      oper_q      <= OPER_RST;
      nodeId_q    <= NODE_RST;
      cobDis_q    <= COB_DIS_RST;
      ttype_q     <= TTYPE_RST;
      inhibit_q   <= INHIBIT_RST;
      evtPeriod_q <= EVT_RST;
      syncId_q    <= SYNCID_RST;
    end else begin
      ack_q       <= ack_d;
      waitReq_q   <= waitReq_d;
      rdata_q     <= rdata_d;
      oper_q      <= oper_d;
      nodeId_q    <= nodeId_d;
      cobDis_q    <= cobDis_d;
      ttype_q     <= ttype_d;
      inhibit_q   <= inhibit_d;
      evtPeriod_q <= evtPeriod_d;
      syncId_q    <= syncId_d;
    end
  end

  assign tick    = (tickCnt_q == TICK_W'(TICK_CYCLES - 1));
  assign msTick  = tick & (msCnt_q == 4'(TICKS_PER_MS - 1));
  assign evtFire = msTick & (evtPeriod_q != 16'h0000) & ((evtCnt_q + 16'h0001) >= evtPeriod_q);
  assign evtSrc  = incChange | evtFire;
  assign canSend = oper_q & ~cobDis_q;
  assign syncHit = rxValid & ~rxRtr & (rxId == syncId_q) & oper_q;
  assign rtrHit  = rxValid & rxRtr & (rxId == txBaseId) & canSend;
  assign isCyc   = isCyclic(ttype_q);
  assign syncDone = syncHit & isCyc & ((syncCnt_q + 8'h01) >= ttype_q);

  assign trig = rtrHit
              | (canSend & syncDone)
              | (canSend & (ttype_q == TTYPE_ASYNC) & evtSrc)
              | (canSend & (ttype_q == TTYPE_ACYC) & syncHit & evtPend_q);

  assign intValid = pend_q & canSend & (inhCnt_q == 17'h0_0000);
  assign emit     = intValid & txStream.ready;

  always_comb begin
    tickCnt_d = tick ? '0 : tickCnt_q + 1'b1;
    msCnt_d   = msCnt_q;
    if (tick) begin
      msCnt_d = msTick ? 4'h0 : msCnt_q + 4'h1;
    end
    evtCnt_d = evtCnt_q;
    if (wrEvt || evtPeriod_q == 16'h0000 || evtFire) begin
      evtCnt_d = 16'h0000;
    end else if (msTick) begin
      evtCnt_d = evtCnt_q + 16'h0001;
    end
    syncCnt_d = syncCnt_q;
    if (wrTtype || !isCyc || syncDone) begin
      syncCnt_d = 8'h00;
    end else if (syncHit) begin
      syncCnt_d = syncCnt_q + 8'h01;
    end
    evtPend_d = 1'b0;
    if (canSend && ttype_q == TTYPE_ACYC) begin
      evtPend_d = (evtPend_q & ~syncHit) | evtSrc;
    end
    // New trigger wins over the clear by a send
    pend_d = canSend & ((pend_q & ~emit) | trig);
    // loaded plus one so the gap is never short
    inhCnt_d = inhCnt_q;
    if (emit) begin
      inhCnt_d = (inhibit_q == 16'h0000) ? 17'h0_0000 : {1'b0, inhibit_q} + 17'h0_0001;
    end else if (tick && inhCnt_q != 17'h0_0000) begin
      inhCnt_d = inhCnt_q - 17'h0_0001;
    end
    txCount_d = emit ? txCount_q + 16'h0001 : txCount_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tickCnt_q <= '0;
      msCnt_q   <= 4'h0;
      evtCnt_q  <= 16'h0000;
      syncCnt_q <= 8'h00;
      evtPend_q <= 1'b0;
      pend_q    <= 1'b0;
      inhCnt_q  <= 17'h0_0000;
      txCount_q <= 16'h0000;
    end else begin
      tickCnt_q <= tickCnt_d;
      msCnt_q   <= msCnt_d;
      evtCnt_q  <= evtCnt_d;
      syncCnt_q <= syncCnt_d;
      evtPend_q <= evtPend_d;
      pend_q    <= pend_d;
      inhCnt_q  <= inhCnt_d;
      txCount_q <= txCount_d;
    end
  end

  // Measurement captured at send time, not at trigger time
  assign txStream.valid = intValid;
  assign txStream.data  = {txBaseId, measValue};

  tx_skid_buffer #(.W(TX_W)) txBuf (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inPort   (txStream),
    .outValid (txValid),
    .outData  ({txId, txData}),
    .outReady (txReady)
  );

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitReq_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_cyc_send;
    canSend && syncHit && isCyc && (syncCnt_q == ttype_q - 8'h01) && !wrHit |=> pend_q;
  endproperty
  a_cyc_send: assert property (p_cyc_send) else $error("Nth SYNC did not queue a send");

  property p_acyc_send;
    canSend && ttype_q == TTYPE_ACYC && evtPend_q && syncHit && !wrHit |=> pend_q;
  endproperty
  a_acyc_send: assert property (p_acyc_send) else $error("Event plus SYNC did not queue a send");

  property p_acyc_quiet;
    ttype_q == TTYPE_ACYC && !pend_q && !evtPend_q && !rtrHit |=> !pend_q;
  endproperty
  a_acyc_quiet: assert property (p_acyc_quiet) else $error("Type 0 sent without event");

  property p_rtr;
    rtrHit |=> pend_q ##[0:2] intValid || inhCnt_q != 17'h0_0000;
  endproperty
  a_rtr: assert property (p_rtr) else $error("Remote request not answered");

  property p_rtr_only;
    ttype_q == TTYPE_RTR && !pend_q && !rtrHit |=> !pend_q;
  endproperty
  a_rtr_only: assert property (p_rtr_only) else $error("Type 253 sent without remote request");

  property p_async;
    canSend && ttype_q == TTYPE_ASYNC && incChange && !wrHit |=> pend_q;
  endproperty
  a_async: assert property (p_async) else $error("Change event not queued");

  property p_evt_timer;
    canSend && ttype_q == TTYPE_ASYNC && evtFire && !wrHit |=> pend_q && evtCnt_q == 16'h0000;
  endproperty
  a_evt_timer: assert property (p_evt_timer) else $error("Timer expiry not queued");

  property p_evt_off;
    evtPeriod_q == 16'h0000 |-> !evtFire && evtCnt_q == 16'h0000;
  endproperty
  a_evt_off: assert property (p_evt_off) else $error("Disabled event timer fired");

  property p_inh_load;
    emit && inhibit_q != 16'h0000 |=> inhCnt_q == {1'b0, $past(inhibit_q)} + 17'h0_0001;
  endproperty
  a_inh_load: assert property (p_inh_load) else $error("Inhibit not started");

  property p_inh_block;
    inhCnt_q != 17'h0_0000 |-> !emit;
  endproperty
  a_inh_block: assert property (p_inh_block) else $error("Send during inhibit");

  property p_inh_lock;
    wrHit && avs_address == OFS_INHIBIT && !cobDis_q |=> $stable(inhibit_q);
  endproperty
  a_inh_lock: assert property (p_inh_lock) else $error("Inhibit changed while enabled");

  property p_sync_id;
    syncId_q != 11'h000;
  endproperty
  a_sync_id: assert property (p_sync_id) else $error("SYNC identifier zero");

  property p_sync_restart;
    syncDone && !wrTtype |=> syncCnt_q == 8'h00;
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("SYNC counter not restarted");

  property p_sync_oper;
    !oper_q && !wrTtype |=> $stable(syncCnt_q);
  endproperty
  a_sync_oper: assert property (p_sync_oper) else $error("SYNC counted while not operational");

  c_sync: cover property (canSend && syncDone ##[1:3] emit);
  c_rtr: cover property (rtrHit ##[1:3] emit);
  c_async: cover property (canSend && ttype_q == TTYPE_ASYNC && evtFire ##[1:3] emit);
  c_inhibit: cover property (pend_q && inhCnt_q != 17'h0_0000);
  c_stall: cover property (intValid && !txStream.ready);

endmodule : tpdo_transmission_scheduler

// ===== verification/can_master_model.sv
`timescale 1ns/1ns
module can_master_model (
  input  wire logic        sys_clk,  // Clock
  input  wire logic        rst,      // Synchronous reset
  input  wire logic [1:0]  stall,    // 0 prompt, 1 random, 2 hold
  output logic             rxValid,  // Frame pulse
  output logic [10:0]      rxId,     // Frame identifier
  output logic             rxRtr,    // Remote request flag
  input  wire logic        txValid,  // Frame offered
  input  wire logic [10:0] txId,     // Offered identifier
  input  wire logic [31:0] txData,   // Offered payload
  output logic             txReady,  // Frame taken
  output int               nRx,      // Frames taken
  output logic [10:0]      lastId,   // Last identifier
  output logic [31:0]      lastData  // Last payload
);
  int seed = 32'h8e26_ba66;

  initial begin
    rxValid = 1'b0;
    rxId    = 11'h000;
    rxRtr   = 1'b0;
  end

  // Idle lines show the inverse, never the last frame
  task automatic send(input logic [10:0] id, input logic rtr);
    rxValid <= 1'b1;
    rxId    <= id;
    rxRtr   <= rtr;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxId    <= ~id;
    rxRtr   <= ~rtr;
  endtask : send

  always @(posedge sys_clk) begin
    if (rst) begin
      nRx     <= 0;
      txReady <= 1'b0;
    end else begin
      if (txValid && txReady) begin
        nRx      <= nRx + 1;
        lastId   <= txId;
        lastData <= txData;
      end
      txReady <= (stall == 2'd0) || (stall == 2'd1 && ($random(seed) & 3) == 0);
    end
  end
endmodule : can_master_model

// ===== verification/tpdo_transmission_scheduler_test.sv
`timescale 1ns/1ns
module tpdo_transmission_scheduler_test;
  import tpdo_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  addr_t       avsAddr   = 8'h00;
  logic        avsRd     = 1'b0;
  logic        avsWr     = 1'b0;
  word_t       avsWdata  = 32'h0000_0000;
  word_t       avsRdata;
  logic        avsWait;
  logic        rxValid;
  logic [10:0] rxId;
  logic        rxRtr;
  logic        incChange = 1'b0;
  word_t       measValue = 32'h0000_0000;
  logic        txValid;
  logic [10:0] txId;
  word_t       txData;
  logic        txReady;
  logic [1:0]  stall     = 2'd0;
  int          nRx;
  logic [10:0] lastId;
  word_t       lastData;
  int          n_fail    = 0;
  int          cmp_count = 0;
  int          seed      = 32'h8e26_ba66;
  int          cyc       = 0;
  int          base;
  int          n;
  logic [6:0]  node;
  logic [10:0] sid;
  logic [7:0]  tt[6]     = '{8'h00, 8'h05, 8'hF0, 8'hFD, 8'hFE, 8'hFF};
  addr_t       ra[9]     = '{OFS_CTRL, OFS_COBID, OFS_TTYPE, OFS_INHIBIT, OFS_EVT, OFS_SYNCID,
                             OFS_STATUS, 8'h1C, 8'h02};
  word_t       rv[9]     = '{32'h0000_0100, 32'h0000_0181, 32'h0000_00FE, 32'h0000_0000,
                             32'h0000_0000, 32'h0000_0080, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_0000};

  always #5 sys_clk = ~sys_clk;

  tpdo_transmission_scheduler #(.TICK_CYCLES(10)) tpdo_transmission_scheduler_i (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avsAddr), .avs_read(avsRd), .avs_write(avsWr),
    .avs_writedata(avsWdata), .avs_byteenable(4'hF), .avs_readdata(avsRdata),
    .avs_waitrequest(avsWait), .rxValid(rxValid), .rxId(rxId), .rxRtr(rxRtr),
    .incChange(incChange), .measValue(measValue), .txValid(txValid), .txId(txId),
    .txData(txData), .txReady(txReady));

  can_master_model can_master_model_i (
    .sys_clk(sys_clk), .rst(rst), .stall(stall), .rxValid(rxValid), .rxId(rxId), .rxRtr(rxRtr),
    .txValid(txValid), .txId(txId), .txData(txData), .txReady(txReady), .nRx(nRx),
    .lastId(lastId), .lastData(lastData));

  function automatic logic [10:0] tpdo_id(input logic [6:0] nd);
    return TPDO_BASE_ID + {4'h0, nd};
  endfunction : tpdo_id

  function automatic int sync_frames(input int syncs, input logic [7:0] t);
    return (t >= 8'd1 && t <= 8'd240) ? syncs / int'(t) : 0;
  endfunction : sync_frames

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input word_t g, input word_t e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_cnt(input int g, input int e);
    cmp_count++;
    if (g != e) begin
      n_fail++;
      $display("mismatch at %0t: %0d frames expected %0d", $time, g, e);
    end
  endtask : chk_cnt

  // Request held until the rising edge that sees waitrequest low; values read here predate that edge
  task automatic bus(input addr_t a, input logic w, input word_t d, output word_t q);
    avsAddr  <= a;
    avsWdata <= d;
    avsWr    <= w;
    avsRd    <= !w;
    do @(posedge sys_clk); while (avsWait !== 1'b0);
    q = avsRdata;
    avsWr <= 1'b0;
    avsRd <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input addr_t a, input word_t d);
    word_t q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic chk_reg(input addr_t a, input word_t e);
    word_t q;
    bus(a, 1'b0, 32'h0000_0000, q);
    chk_word(q, e);
  endtask : chk_reg

  task automatic frame(input logic [10:0] id, input logic r, input int k);
    repeat (k) begin
      can_master_model_i.send(id, r);
      @(posedge sys_clk);
    end
  endtask : frame

  task automatic event_pulse;
    measValue <= $random(seed);
    incChange <= 1'b1;
    @(posedge sys_clk);
    incChange <= 1'b0;
  endtask : event_pulse

  task automatic quiet(input int k, input int e);
    repeat (k) @(posedge sys_clk);
    chk_cnt(nRx, e);
  endtask : quiet

  task automatic expect_rx(input int e);
    for (int i = 0; i < 40 && nRx < e; i++) @(posedge sys_clk);
    chk_cnt(nRx, e);
  endtask : expect_rx

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : done

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_of_test;
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ra[i]) chk_reg(ra[i], rv[i]);
    done("reset");
    node = 7'($random(seed)) | 7'h01;
    sid  = 11'($random(seed) & 32'h7F) | 11'h001;
    wr(OFS_SYNCID, 32'(sid));
    wr(OFS_SYNCID, 32'h0000_0000);
    chk_reg(OFS_SYNCID, 32'(sid));
    wr(OFS_CTRL, 32'(node) << 8);
    wr(OFS_TTYPE, 32'h0000_0001);
    frame(sid, 1'b0, 2);
    event_pulse;
    frame(tpdo_id(node), 1'b1, 1);
    quiet(20, 0);
    done("idle");
    wr(OFS_CTRL, (32'(node) << 8) | 32'h0000_0001);
    chk_reg(OFS_COBID, 32'(tpdo_id(node)));
    wr(OFS_TTYPE, 32'h0000_00FE);
    event_pulse;
    expect_rx(1);
    chk_word(lastData, measValue);
    chk_word(32'(lastId), 32'(tpdo_id(node)));
    stall <= 2'd1;
    foreach (tt[i]) begin
      wr(OFS_TTYPE, 32'(tt[i]));
      base = nRx;
      frame(tpdo_id(node), 1'b1, 1);
      expect_rx(base + 1);
    end
    base = nRx;
    frame(tpdo_id(node) + 11'h001, 1'b1, 1);
    frame(tpdo_id(node), 1'b0, 1);
    quiet(10, base);
    wr(OFS_TTYPE, 32'(TTYPE_RTR));
    event_pulse;
    frame(sid, 1'b0, 1);
    quiet(10, base);
    done("remote");
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 1 : (k == 1) ? 2 + ($random(seed) & 15) : 240;
      wr(OFS_TTYPE, 32'(n));
      base = nRx;
      frame(sid, 1'b0, n - 1);
      quiet(5, base + sync_frames(n - 1, 8'(n)));
      frame(sid, 1'b0, 1);
      expect_rx(base + sync_frames(n, 8'(n)));
      frame(sid, 1'b0, n);
      expect_rx(base + 2);
    end
    done("cyclic");
    wr(OFS_TTYPE, 32'(TTYPE_ACYC));
    base = nRx;
    frame(sid, 1'b0, 1);
    event_pulse;
    quiet(10, base);
    frame(sid, 1'b0, 1);
    expect_rx(base + 1);
    done("acyclic");
    wr(OFS_TTYPE, 32'(TTYPE_ASYNC));
    base = nRx;
    quiet(300, base);
    // Period kept at the advised floor
    wr(OFS_EVT, 32'd50);
    quiet(10100, base + 2);
    wr(OFS_EVT, 32'h0000_0000);
    done("timer");
    stall <= 2'd2;
    base = nRx;
    repeat (3) begin
      event_pulse;
      repeat (3) @(posedge sys_clk);
    end
    quiet(20, base);
    chk_word(32'(txValid), 32'h0000_0001);
    stall <= 2'd0;
    expect_rx(base + 3);
    done("stall");
    wr(OFS_INHIBIT, 32'd20);
    chk_reg(OFS_INHIBIT, 32'h0000_0000);
    // Disable before touching the inhibit time
    wr(OFS_COBID, 32'h8000_0000);
    base = nRx;
    frame(tpdo_id(node), 1'b1, 1);
    quiet(10, base);
    wr(OFS_INHIBIT, 32'd20);
    chk_reg(OFS_INHIBIT, 32'd20);
    wr(OFS_COBID, 32'h0000_0000);
    event_pulse;
    expect_rx(base + 1);
    event_pulse;
    quiet(180, base + 1);
    expect_rx(base + 2);
    done("inhibit");
    end_of_test;
  end
endmodule : tpdo_transmission_scheduler_test
